//--- src/gfs_params.svh
// Constants of the gate fault supervisor: offsets, fields, resets and timing
`ifndef GFS_PARAMS_SVH
`define GFS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GFS_OFS_CTRL      12'h000
`define GFS_OFS_FAULT     12'h004
`define GFS_OFS_STAT      12'h008

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GFS_CTRL_DUAL     0
`define GFS_CTRL_PFIMM    1
`define GFS_STAT_VLD      4
`define GFS_STAT_TRBL     8
`define GFS_STAT_LINK     9
`define GFS_STAT_DBL      10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GFS_CTRL_RST      2'h0
`define GFS_CODE_NONE     4'hf

// ----------------------------------------------------------------------
// Timing: clock rate, then times in ms or s and derived counts
// ----------------------------------------------------------------------
`define GFS_CLK_KHZ       20000
`define GFS_MS_CYC        (`GFS_CLK_KHZ * 1)
`define GFS_BLINK_MS      1000
`define GFS_BEEP_MS       500
`define GFS_FAST_MS       (`GFS_BEEP_MS / 2)
`define GFS_PHASE_MS      5000
`define GFS_CHIRP_MS      50
`define GFS_DBL_ON_MS     100
`define GFS_DBL_GAP_MS    200
`define GFS_LINK_ALM_MS   60000
`define GFS_RUN_TAIL_MS   300000
`define GFS_SEC_MS        1000
`define GFS_MISS_S        3900

`endif

//--- src/gfs_pkg.sv
// Types of the gate fault supervisor
package gfs_pkg;

    // ------------------------------------------------------------------
    // Fault codes, one latch bit each
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        GFS_EN00 = 4'h0, GFS_EN01 = 4'h1, GFS_EN02 = 4'h2, GFS_EN03 = 4'h3,
        GFS_EN04 = 4'h4, GFS_EN05 = 4'h5, GFS_EN06 = 4'h6, GFS_EN07 = 4'h7,
        GFS_EN08 = 4'h8, GFS_EN09 = 4'h9, GFS_EN10 = 4'ha, GFS_EN11 = 4'hb,
        GFS_EN12 = 4'hc, GFS_EN13 = 4'hd, GFS_EN14 = 4'he
    } gfs_code_t;

    // ------------------------------------------------------------------
    // Sense bundle from motion, power and radio logic (same clock)
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rev_ev;          // Safety reversal, pulse
        logic peer_rev_ev;     // Reversal reported by paired gate, pulse
        logic travel_done;     // Limit reached, pulse
        logic run_limit_ev;    // Max run time elapsed, pulse
        logic run_dir_open;    // Direction at overrun
        logic move_start;      // Gate operation begins, pulse
        logic at_open;         // Full open limit, level
        logic any_cmd_ev;      // Any gate input activated, pulse
        logic prestart;        // Pre-start warning phase, level
        logic running;         // Gate travelling, level
        logic mains_lost;      // No mains, level
        logic mains_low;       // Mains below normal, level
        logic batt_below_low;  // Battery under low threshold
        logic batt_above_high; // Battery over recovery threshold
        logic peer_entrap;     // Paired unit in lockout, level
        logic fw_incompat;     // Firmware mismatch with peer
        logic nvm_fault;       // Nonvolatile memory fault
        logic motor_chk_ev;    // Motor board check done, pulse
        logic motor_chk_ok;    // Result of that check
        logic motor_fail;      // Motor failure detected, pulse
        logic tx_status_ev;    // Transmitter status report, pulse
        logic tx_lowbat;       // Transmitter low battery, level
        logic tx_tamper;       // Transmitter case open, level
    } gfs_sense_t;

    // ------------------------------------------------------------------
    // Whole state of the top module
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [14:0] ms_div;
        logic [9:0]  sec_div;
        logic [12:0] phase;
        logic [11:0] miss_s;
        logic [18:0] tail_ms;
        logic [15:0] link_ms;
        logic [1:0]  rev_cnt;
        logic [14:0] faults;
        logic [3:0]  code;
        logic        code_vld;
        logic        alarm;
        logic        link_alm;
        logic        dbl_beep;
        logic        emerg;
        logic        run_q;
        logic        stop_q;
        logic        emerg_q;
        logic [1:0]  ctrl;
        logic        aw_have;
        logic        w_have;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic        wstb0;
        logic        awrdy;
        logic        wrdy;
        logic        arrdy;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic        beep;
        logic        link_led;
        logic        maxrun_led;
        logic        gate_en;
        logic        cmd_allow;
        logic        emerg_cmd;
        logic        trouble;
    } gfs_state_t;

endpackage

//--- src/gfs_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none

module gfs_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // Pins and filtered levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] lvl_out
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    // Only stage two reads stage one; a bit moves once stages two and three agree
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s1_ff   <= '0;
            s2_ff   <= '0;
            s3_ff   <= '0;
            lvl_out <= '0;
        end else begin
            s1_ff   <= pin_in;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            lvl_out <= (s2_ff & s3_ff) | (lvl_out & (s2_ff | s3_ff));
        end
    end

endmodule

`default_nettype wire

//--- src/gfs_top.sv
// Gate fault supervisor: fault latches, code display, beeper and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "gfs_params.svh"

// Operation
// - Blink link LED once per second on failure
// - Link failure blocks commands except emergency open
// - Flag transmitter battery, tamper or missing reports
// - Trouble doubles pre-start beep rate
// - Trouble doubles run beep, five-minute tail
// - Trouble chirps every five seconds when idle
// - Trouble indications drop when condition ends
// - Run overrun on mains stops, locks out until stop
// - Two reversals give En 00, alarm, lockout
// - Overrun on mains gives En 01/02, LED, double beep
// - Link failure gives En 03, one-minute alarm
// - Emergency full open gives En 04 lockout
// - Battery low En 05, En 14, clear above 24V
// - Peer entrapment gives En 06 until cleared
// - Low mains gives En 07 until restored
// - Input during lockout gives En 08
// - Firmware mismatch En 09, memory fault En 10
// - Motor mismatch En 11, rechecked next movement
// - Motor failure En 12 until service
// - Mains loss in immediate mode shows En 13
// - Emergency open drives fully open, holds locked
// - Two obstruction triggers enter entrapment lockout
module gfs_top #(
    parameter int MS_CYC = `GFS_MS_CYC
) (
    // Clock and reset
    input  wire logic              MCLK_IN,
    input  wire logic              RST_N_IN,
    // Pins: stop button, emergency open, paired link healthy
    input  wire logic              STOP_BTN_IN,
    input  wire logic              EMERG_OPEN_IN,
    input  wire logic              LINK_OK_IN,
    // Sense bundle from neighbouring logic
    input  wire gfs_pkg::gfs_sense_t SENSE_IN,
    // Indications and gate permissions
    output logic                   BEEP_OUT,
    output logic                   LINK_LED_OUT,
    output logic                   MAXRUN_LED_OUT,
    output logic [3:0]             CODE_OUT,
    output logic                   CODE_VLD_OUT,
    output logic                   TROUBLE_OUT,
    output logic                   GATE_EN_OUT,
    output logic                   CMD_ALLOW_OUT,
    output logic                   EMERG_OPEN_CMD_OUT,
    // AXI4-Lite slave
    input  wire logic [11:0]       S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [11:0]       S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Lowest set fault index, or none
    function automatic logic [3:0] first_set(input logic [14:0] m);
        logic [3:0] r;
        r = `GFS_CODE_NONE;
        for (int i = 14; i >= 0; i--) begin
            if (m[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // True in the first half of a repeating period of p ms
    function automatic logic in_on(input logic [12:0] ph, input int p);
        return (32'(ph) % p) < (p / 2);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pins;

    gfs_sync #(
        .W(3)
    ) u_sync (
        .clk_in  (MCLK_IN),
        .rst_n_in(RST_N_IN),
        .pin_in  ({LINK_OK_IN, EMERG_OPEN_IN, STOP_BTN_IN}),
        .lvl_out (pins)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    gfs_pkg::gfs_state_t s_ff;
    gfs_pkg::gfs_state_t nxt_s;
    logic [14:0]         set_m;
    logic [14:0]         clr_m;
    logic                ms_tick;
    logic                stop_ev;
    logic                emerg_ev;
    logic                link_fail;
    logic                lockout;
    logic                missing;
    logic                trbl;
    logic                idle;
    logic                wr_go;
    logic                disable_any;

    // Next-state logic
    always_comb begin
        nxt_s = s_ff;
        set_m = '0;
        clr_m = '0;
        // Millisecond, second and 5 s phase timebase
        ms_tick = (s_ff.ms_div == 15'(MS_CYC - 1));
        nxt_s.ms_div = ms_tick ? 15'h0 : s_ff.ms_div + 15'h1;
        if (ms_tick) begin
            nxt_s.sec_div = (s_ff.sec_div == 10'(`GFS_SEC_MS - 1)) ? 10'h0 : s_ff.sec_div + 10'h1;
            nxt_s.phase = (s_ff.phase == 13'(`GFS_PHASE_MS - 1)) ? 13'h0 : s_ff.phase + 13'h1;
        end
        nxt_s.stop_q  = pins[0];
        nxt_s.emerg_q = pins[1];
        nxt_s.run_q   = SENSE_IN.running;
        stop_ev  = pins[0] & ~s_ff.stop_q;
        emerg_ev = pins[1] & ~s_ff.emerg_q;
        link_fail = s_ff.ctrl[`GFS_CTRL_DUAL] & ~pins[2];
        lockout = |s_ff.faults[2:0];
        // Missing status reports: seconds since last report
        // report supervision
        if (SENSE_IN.tx_status_ev) begin
            nxt_s.miss_s = 12'h0;
        end else if (ms_tick && s_ff.sec_div == 10'h0 && s_ff.miss_s != 12'(`GFS_MISS_S)) begin
            nxt_s.miss_s = s_ff.miss_s + 12'h1;
        end
        missing = (s_ff.miss_s == 12'(`GFS_MISS_S));
        trbl = SENSE_IN.tx_lowbat | SENSE_IN.tx_tamper | missing;
        // Reversal counter; two in one travel is entrapment
        // two obstruction triggers
        if (stop_ev || SENSE_IN.travel_done) begin
            nxt_s.rev_cnt = 2'h0;
        end else if ((SENSE_IN.rev_ev || SENSE_IN.peer_rev_ev) && s_ff.rev_cnt != 2'h2) begin
            nxt_s.rev_cnt = s_ff.rev_cnt + 2'h1;
        end
        set_m[0] = (nxt_s.rev_cnt == 2'h2) & (s_ff.rev_cnt != 2'h2);
        // direction selects En 01 or En 02
        set_m[1] = SENSE_IN.run_limit_ev & SENSE_IN.run_dir_open & ~SENSE_IN.mains_lost;
        set_m[2] = SENSE_IN.run_limit_ev & ~SENSE_IN.run_dir_open & ~SENSE_IN.mains_lost;
        set_m[3] = link_fail;
        clr_m[3] = ~link_fail;
        set_m[4] = s_ff.emerg & SENSE_IN.at_open;
        // battery faults, recovery above high threshold
        set_m[5]  = SENSE_IN.mains_lost & SENSE_IN.batt_below_low;
        set_m[14] = SENSE_IN.run_limit_ev & SENSE_IN.mains_lost;
        clr_m[5]  = SENSE_IN.batt_above_high;
        clr_m[14] = SENSE_IN.batt_above_high;
        set_m[6] = SENSE_IN.peer_entrap;
        clr_m[6] = ~SENSE_IN.peer_entrap;
        set_m[7] = SENSE_IN.mains_low;
        clr_m[7] = ~SENSE_IN.mains_low;
        set_m[8] = lockout & (SENSE_IN.any_cmd_ev | emerg_ev);
        set_m[9]  = SENSE_IN.fw_incompat;
        clr_m[9]  = ~SENSE_IN.fw_incompat;
        set_m[10] = SENSE_IN.nvm_fault;
        clr_m[10] = ~SENSE_IN.nvm_fault;
        // motor check retried on each movement
        set_m[11] = SENSE_IN.motor_chk_ev & ~SENSE_IN.motor_chk_ok;
        clr_m[11] = SENSE_IN.motor_chk_ev & SENSE_IN.motor_chk_ok;
        set_m[12] = SENSE_IN.motor_fail;
        set_m[13] = SENSE_IN.mains_lost & s_ff.ctrl[`GFS_CTRL_PFIMM];
        clr_m[13] = ~SENSE_IN.mains_lost;
        // Stop button releases the button-cleared latches
        if (stop_ev) begin
            clr_m[0] = 1'b1;
            clr_m[1] = 1'b1;
            clr_m[2] = 1'b1;
            clr_m[4] = 1'b1;
            clr_m[8] = 1'b1;
        end
        // A set in the same cycle as its clear wins
        nxt_s.faults = (s_ff.faults & ~clr_m) | set_m;
        // newest fault shown, fall back when it clears
        if (|(set_m & ~s_ff.faults)) begin
            nxt_s.code = first_set(set_m & ~s_ff.faults);
        end else if (s_ff.code == `GFS_CODE_NONE || !nxt_s.faults[s_ff.code]) begin
            nxt_s.code = first_set(nxt_s.faults);
        end
        // Continuous alarm for entrapment and overrun until stop
        if (|set_m[2:0]) begin
            nxt_s.alarm = 1'b1;
        end else if (stop_ev) begin
            nxt_s.alarm = 1'b0;
        end
        // double beep after stop until next operation
        if (stop_ev && |s_ff.faults[2:1]) begin
            nxt_s.dbl_beep = 1'b1;
        end else if (SENSE_IN.move_start) begin
            nxt_s.dbl_beep = 1'b0;
        end
        // one minute of alarm, stop silences it
        if (set_m[3] && !s_ff.faults[3]) begin
            nxt_s.link_alm = 1'b1;
            nxt_s.link_ms  = 16'h0;
        end else if (stop_ev || s_ff.link_ms == 16'(`GFS_LINK_ALM_MS)) begin
            nxt_s.link_alm = 1'b0;
        end else if (s_ff.link_alm && ms_tick) begin
            nxt_s.link_ms = s_ff.link_ms + 16'h1;
        end
        if (emerg_ev) begin
            nxt_s.emerg = 1'b1;
        end else if (stop_ev) begin
            nxt_s.emerg = 1'b0;
        end
        // run alarm tail after gate stops
        if (SENSE_IN.running) begin
            nxt_s.tail_ms = 19'h0;
        end else if (s_ff.run_q && trbl) begin
            nxt_s.tail_ms = 19'(`GFS_RUN_TAIL_MS);
        end else if (ms_tick && s_ff.tail_ms != 19'h0) begin
            nxt_s.tail_ms = s_ff.tail_ms - 19'h1;
        end
        if (!trbl) begin
            nxt_s.tail_ms = 19'h0;
        end
        idle = ~SENSE_IN.running & ~SENSE_IN.prestart & (s_ff.tail_ms == 19'h0);
        // Beeper priority: continuous, prestart/run, double beep, chirp
        if (s_ff.alarm || s_ff.link_alm) begin
            nxt_s.beep = 1'b1;
        end else if (SENSE_IN.prestart || SENSE_IN.running || s_ff.tail_ms != 19'h0) begin
            nxt_s.beep = trbl ? in_on(s_ff.phase, `GFS_FAST_MS) : in_on(s_ff.phase, `GFS_BEEP_MS);
        end else if (s_ff.dbl_beep) begin
            nxt_s.beep = (s_ff.phase < 13'(`GFS_DBL_ON_MS)) ||
                         (s_ff.phase >= 13'(`GFS_DBL_GAP_MS) &&
                          s_ff.phase < 13'(`GFS_DBL_GAP_MS + `GFS_DBL_ON_MS));
        end else if (trbl && idle) begin
            nxt_s.beep = (s_ff.phase < 13'(`GFS_CHIRP_MS));
        end else begin
            nxt_s.beep = 1'b0;
        end
        // link LED blinks at 1 Hz
        nxt_s.link_led   = link_fail & in_on(s_ff.phase, `GFS_BLINK_MS);
        nxt_s.maxrun_led = |nxt_s.faults[2:1];
        nxt_s.code_vld   = nxt_s.code != `GFS_CODE_NONE;
        nxt_s.trouble    = trbl;
        // En 13 and En 14 indicate only; every other fault stops the gate
        disable_any       = |(nxt_s.faults & 15'h1fff);
        nxt_s.gate_en     = ~disable_any & ~nxt_s.emerg;
        nxt_s.cmd_allow   = ~disable_any & ~nxt_s.emerg & ~link_fail;
        nxt_s.emerg_cmd   = nxt_s.emerg;
        // AXI4-Lite write: address and data in either order
        if (S_AXI_AWVALID && s_ff.awrdy) begin
            nxt_s.aw_have = 1'b1;
            nxt_s.awaddr  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s_ff.wrdy) begin
            nxt_s.w_have = 1'b1;
            nxt_s.wdata  = S_AXI_WDATA;
            nxt_s.wstb0  = S_AXI_WSTRB[0];
        end
        wr_go = s_ff.aw_have & s_ff.w_have & ~s_ff.bvalid;
        if (wr_go) begin
            nxt_s.aw_have = 1'b0;
            nxt_s.w_have  = 1'b0;
            nxt_s.bvalid  = 1'b1;
            nxt_s.bresp   = 2'h0;
            if ({s_ff.awaddr[11:2], 2'h0} == `GFS_OFS_CTRL) begin
                if (s_ff.wstb0) begin
                    nxt_s.ctrl = s_ff.wdata[1:0];
                end
            end else if ({s_ff.awaddr[11:2], 2'h0} != `GFS_OFS_FAULT &&
                         {s_ff.awaddr[11:2], 2'h0} != `GFS_OFS_STAT) begin
                nxt_s.bresp = 2'h2;
            end
        end else if (s_ff.bvalid && S_AXI_BREADY) begin
            nxt_s.bvalid = 1'b0;
        end
        // AXI4-Lite read, one cycle after the address is taken
        if (S_AXI_ARVALID && s_ff.arrdy) begin
            nxt_s.rvalid = 1'b1;
            case ({S_AXI_ARADDR[11:2], 2'h0})
                `GFS_OFS_CTRL: begin
                    nxt_s.rdata = {30'h0, s_ff.ctrl};
                end
                `GFS_OFS_FAULT: begin
                    nxt_s.rdata = {17'h0, s_ff.faults};
                end
                `GFS_OFS_STAT: begin
                    nxt_s.rdata = {21'h0, s_ff.dbl_beep, link_fail, trbl, 3'h0,
                                   s_ff.code_vld, s_ff.code};
                end
                default: begin
                    nxt_s.rdata = 32'h0;
                end
            endcase
        end else if (s_ff.rvalid && S_AXI_RREADY) begin
            nxt_s.rvalid = 1'b0;
        end
        // Ready flags registered so they come straight from flops
        nxt_s.awrdy = ~nxt_s.aw_have & ~nxt_s.bvalid;
        nxt_s.wrdy  = ~nxt_s.w_have & ~nxt_s.bvalid;
        nxt_s.arrdy = ~nxt_s.rvalid;
    end

    // State register, synchronous active-low reset
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            s_ff         <= '0;
            s_ff.code    <= `GFS_CODE_NONE;
            s_ff.ctrl    <= `GFS_CTRL_RST;
            s_ff.gate_en <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign BEEP_OUT           = s_ff.beep;
    assign LINK_LED_OUT       = s_ff.link_led;
    assign MAXRUN_LED_OUT     = s_ff.maxrun_led;
    assign CODE_OUT           = s_ff.code;
    assign CODE_VLD_OUT       = s_ff.code_vld;
    assign TROUBLE_OUT        = s_ff.trouble;
    assign GATE_EN_OUT        = s_ff.gate_en;
    assign CMD_ALLOW_OUT      = s_ff.cmd_allow;
    assign EMERG_OPEN_CMD_OUT = s_ff.emerg_cmd;
    assign S_AXI_AWREADY      = s_ff.awrdy;
    assign S_AXI_WREADY       = s_ff.wrdy;
    assign S_AXI_BVALID       = s_ff.bvalid;
    assign S_AXI_BRESP        = s_ff.bresp;
    assign S_AXI_ARREADY      = s_ff.arrdy;
    assign S_AXI_RVALID       = s_ff.rvalid;
    assign S_AXI_RDATA        = s_ff.rdata;
    assign S_AXI_RRESP        = 2'h0;

endmodule

`default_nettype wire

//--- testbench/gfs_peer_model.sv
// Paired controller and obstacle transmitter stand-in
`timescale 1ns/1ps
`default_nettype none
module gfs_peer_model (
    // Clock and scenario control
    input  wire logic clk_in,
    input  wire logic fail_in,
    // Link health and transmitter report
    output logic      link_ok_out,
    output logic      tx_status_out
);
    logic [7:0] cnt_ff = 8'h00;
    // Link health follows the bench's failure command
    assign link_ok_out = !fail_in;
    always @(posedge clk_in) begin
        cnt_ff <= cnt_ff + 8'h01;
    end
    assign tx_status_out = (cnt_ff == 8'hff);
endmodule
`default_nettype wire

//--- testbench/gfs_top_sva.sv
// Port assertions for the gate fault supervisor
`timescale 1ns/1ps
`default_nettype none
module gfs_top_sva (
    // Clock, reset and causes
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic EMERG_OPEN_IN,
    input wire gfs_pkg::gfs_sense_t SENSE_IN,
    // Effects
    input wire logic BEEP_OUT,
    input wire logic LINK_LED_OUT,
    input wire logic MAXRUN_LED_OUT,
    input wire logic [3:0] CODE_OUT,
    input wire logic TROUBLE_OUT,
    input wire logic GATE_EN_OUT,
    input wire logic CMD_ALLOW_OUT,
    input wire logic EMERG_OPEN_CMD_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Latched effects are due one edge after their cause, the alarm beep two edges after, the emergency command 2 to 10 edges after
    property p_rlim; SENSE_IN.run_limit_ev && !SENSE_IN.mains_lost |=> MAXRUN_LED_OUT && !GATE_EN_OUT; endproperty
    a_rlim: assert property (p_rlim) else $error("no overrun lockout");
    property p_alm; SENSE_IN.run_limit_ev && !SENSE_IN.mains_lost |=> ##1 BEEP_OUT [*8]; endproperty
    a_alm: assert property (p_alm) else $error("alarm not continuous");
    property p_link; LINK_LED_OUT |-> !CMD_ALLOW_OUT; endproperty
    a_link: assert property (p_link) else $error("commands open on link loss");
    property p_emg; $rose(EMERG_OPEN_IN) |-> ##[2:10] EMERG_OPEN_CMD_OUT; endproperty
    a_emg: assert property (p_emg) else $error("emergency open ignored");
    property p_bat; $rose(SENSE_IN.mains_lost && SENSE_IN.batt_below_low) |=> CODE_OUT == 4'h5 && !GATE_EN_OUT;
    endproperty
    a_bat: assert property (p_bat) else $error("battery fault missed");
    property p_mlow; $rose(SENSE_IN.mains_low) |=> CODE_OUT == 4'h7 && !GATE_EN_OUT; endproperty
    a_mlow: assert property (p_mlow) else $error("low mains missed");
    property p_trb; SENSE_IN.tx_lowbat || SENSE_IN.tx_tamper |=> TROUBLE_OUT; endproperty
    a_trb: assert property (p_trb) else $error("trouble not flagged");
    property p_clr; $fell(SENSE_IN.tx_tamper) && !SENSE_IN.tx_lowbat |=> !TROUBLE_OUT; endproperty
    a_clr: assert property (p_clr) else $error("trouble stuck");
    c_rlim: cover property (MAXRUN_LED_OUT);
    c_emg: cover property (EMERG_OPEN_CMD_OUT);
    c_trb: cover property (TROUBLE_OUT);
endmodule
`default_nettype wire

//--- testbench/gate_fault_supervisor_tb.sv
// Self-checking bench for the gate fault supervisor
`timescale 1ns/1ps
`default_nettype none
module gate_fault_supervisor_tb;
    logic c = 1'h0, rn = 1'h0, stp = 1'h0, emg = 1'h0, fail = 1'h0, ok, rep;
    logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
    logic awr, wr_, arr, bv, rv, mled, gen, cal, ecmd, trb, vld;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rdat, rd_d;
    logic [3:0] code;
    logic [1:0] br;
    gfs_pkg::gfs_sense_t sn = '0, sns;
    int error_cnt = 0, checks_done = 0;
    // Clock and transmitter report merge
    always #25 c = !c;
    always_comb begin sns = sn; sns.tx_status_ev = rep; end
    gfs_peer_model peer (.clk_in(c), .fail_in(fail), .link_ok_out(ok), .tx_status_out(rep));
    gfs_top #(.MS_CYC(20)) dut (.MCLK_IN(c), .RST_N_IN(rn), .STOP_BTN_IN(stp), .EMERG_OPEN_IN(emg),
        .LINK_OK_IN(ok), .SENSE_IN(sns), .BEEP_OUT(), .LINK_LED_OUT(), .MAXRUN_LED_OUT(mled),
        .CODE_OUT(code), .CODE_VLD_OUT(vld), .TROUBLE_OUT(trb), .GATE_EN_OUT(gen), .CMD_ALLOW_OUT(cal),
        .EMERG_OPEN_CMD_OUT(ecmd), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_d), .S_AXI_RRESP(), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
    task chk(input string n, input logic [31:0] e, s);
        checks_done++;
        if (s !== e) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end
    endtask
    task cyc(input int n); repeat (n) @(posedge c); endtask
    task press; stp <= 1'h1; cyc(12); stp <= 1'h0; cyc(12); endtask
    // Bus cycles: each valid held until its own ready
    task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ta, tw;
        ta = 0; tw = 0; awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1;
        while (!(ta && tw)) begin
            @(posedge c);
            if (!ta && awr) begin ta = 1; awv <= 1'h0; end
            if (!tw && wr_) begin tw = 1; wv <= 1'h0; end
        end
        bre <= 1'h1; do @(posedge c); while (!bv); r = br; bre <= 1'h0;
    endtask
    task rd(input logic [11:0] a, output logic [31:0] d);
        ara <= a; arv <= 1'h1; rre <= 1'h1; do @(posedge c); while (!arr);
        arv <= 1'h0; do @(posedge c); while (!rv); d = rd_d; rre <= 1'h0;
    endtask
    task t_regs;
        logic [1:0] r;
        rd(12'h008, rdat); chk("stat", 32'h0000000f, rdat);
        wr(12'h000, 32'h00000001, r); chk("bresp", 2'h0, r);
        rd(12'h000, rdat); chk("ctrl", 32'h00000001, rdat);
        wr(12'h00c, 32'h00000003, r); chk("bresp", 2'h2, r);
        rd(12'h00c, rdat); chk("unmapped", 32'h0, rdat);
    endtask
    task t_rlim;
        for (int d = 0; d < 2; d++) begin
            sn.run_dir_open <= d[0]; sn.run_limit_ev <= 1'h1; cyc(1); sn.run_limit_ev <= 1'h0; cyc(3);
            chk("code", 4'h2 - d[3:0], code);
            chk("led_gate", 2'h2, {mled, gen});
            sn.any_cmd_ev <= 1'h1; cyc(1); sn.any_cmd_ev <= 1'h0; cyc(3);
            chk("code", 5'h18, {vld, code});
            press; rd(12'h008, rdat); chk("stat", 32'h0000040f, rdat);
            sn.move_start <= 1'h1; cyc(1); sn.move_start <= 1'h0; cyc(1);
        end
    endtask
    task t_link;
        fail <= 1'h1; cyc(8); chk("code", 4'h3, code);
        chk("allow", 1'h0, cal);
        emg <= 1'h1; cyc(12); emg <= 1'h0; chk("emerg", 1'h1, ecmd);
        fail <= 1'h0; press; chk("release", 7'h2f, {ecmd, cal, vld, code});
    endtask
    task t_lvl;
        logic [22:0] s[5] = '{23'h40, 23'h80, 23'h100, 23'h800, 23'h1400};
        logic [3:0] e[5] = '{4'ha, 4'h9, 4'h6, 4'h7, 4'h5};
        for (int i = 0; i < 5; i++) begin
            sn <= s[i]; cyc(3); chk("code", e[i], code);
            chk("gate", 1'h0, gen);
            sn <= (i == 4) ? 23'h200 : 23'h0; cyc(3); chk("gate", 1'h1, gen);
        end
        sn.tx_tamper <= 1'h1; cyc(3); chk("trouble", 1'h1, trb);
        sn.tx_tamper <= 1'h0; cyc(3); chk("trouble", 1'h0, trb);
    endtask
    task complete_run;
        if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Main sequence, then a watchdog far beyond its length
    initial begin cyc(8); rn <= 1'h1; cyc(1); t_regs; t_rlim; t_link; t_lvl; complete_run; end
    initial begin #2ms; error_cnt++; complete_run; end
endmodule
bind gfs_top gfs_top_sva sva (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .EMERG_OPEN_IN(EMERG_OPEN_IN),
    .SENSE_IN(SENSE_IN), .BEEP_OUT(BEEP_OUT), .LINK_LED_OUT(LINK_LED_OUT), .MAXRUN_LED_OUT(MAXRUN_LED_OUT),
    .CODE_OUT(CODE_OUT), .TROUBLE_OUT(TROUBLE_OUT), .GATE_EN_OUT(GATE_EN_OUT),
    .CMD_ALLOW_OUT(CMD_ALLOW_OUT), .EMERG_OPEN_CMD_OUT(EMERG_OPEN_CMD_OUT));
`default_nettype wire
